// File: core/psimd_pkg.sv
// psimd_pkg: shared constants and operation codes of the packed datapath
// assumes: included first; used by psimd_sad and psimd_top
package psimd_pkg;

  // -------------------------------------------------------------
  // widths
  // -------------------------------------------------------------
  localparam int VEC_W = 128;
  localparam int GPR_W = 64;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int DWORD_W = 32;
  localparam int QWORD_W = 64;
  localparam int SAD_SUMS = 8;
  localparam int SAD_GROUP = 4;
  localparam int HMIN_LANES = 8;
  localparam int HMIN_POS_LSB = 16;
  localparam int HMIN_POS_W = 3;
  localparam int CNT_W = 8;

  // -------------------------------------------------------------
  // element size codes, log2 of bytes
  // -------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_DWORD = 2'h2;
  localparam logic [1:0] SZ_QWORD = 2'h3;

  // immediate fields of the sum-of-differences operation
  localparam int SAD_BSEL_LSB = 0;
  localparam int SAD_ASEL_BIT = 2;

  localparam logic [WORD_W-1:0] WORD_MAX = 16'hffff;
  localparam logic [DWORD_W-1:0] DWORD_ZERO = 32'h0;

  // -------------------------------------------------------------
  // operations
  // -------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_SIGN_WIDEN,
    OP_ZERO_WIDEN,
    OP_MULTI_SAD,
    OP_HMIN_POS,
    OP_MASKED_TEST,
    OP_QUAD_EQ,
    OP_QUAD_GT,
    OP_PACK_US,
    OP_SET_BIT_COUNT,
    OP_LANE_INSERT,
    OP_LANE_EXTRACT,
    OP_LANE_MINMAX
  } psimd_op_e;

endpackage : psimd_pkg

// File: core/psimd_sad.sv
// psimd_sad: eight sums of four absolute byte differences, combinational
// assumes: operands stable for the cycle; result registered by the caller
`timescale 1ns/1ps
module psimd_sad
  import psimd_pkg::*;
(
  input wire logic [VEC_W-1:0] i_a,
  input wire logic [VEC_W-1:0] i_b,
  input wire logic [7:0] i_imm,
  output logic [VEC_W-1:0] o_sum
);

  // -------------------------------------------------------------
  // block selection
  // -------------------------------------------------------------
  logic [1:0] bsel;
  logic asel;
  logic [31:0] bblk;
  assign bsel = i_imm[SAD_BSEL_LSB +: 2];
  assign asel = i_imm[SAD_ASEL_BIT];
  // four reference bytes taken from the second operand
  assign bblk = i_b[bsel * DWORD_W +: DWORD_W];

  // -------------------------------------------------------------
  // one word sum per sliding position
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SAD_SUMS; gi++) begin : g_sum
      always_comb begin
        logic [BYTE_W-1:0] x;
        logic [BYTE_W-1:0] y;
        logic [WORD_W-1:0] acc;
        x = '0;
        y = '0;
        acc = '0;
        for (int k = 0; k < SAD_GROUP; k++) begin
          x = i_a[(asel ? SAD_GROUP * BYTE_W : 0) + (gi + k) * BYTE_W
            +: BYTE_W];
          y = bblk[k * BYTE_W +: BYTE_W];
          acc = acc + WORD_W'((x > y) ? x - y : y - x);
        end
        o_sum[gi * WORD_W +: WORD_W] = acc;
      end
    end
  endgenerate

endmodule : psimd_sad

// File: core/psimd_top.sv
// psimd_top: 128-bit packed-integer datapath, one result per request
// assumes: issue logic on I_CLK drives op and operands with I_VALID for
// one cycle; answers appear one clock later, registered
`timescale 1ns/1ps
module psimd_top
  import psimd_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire psimd_op_e I_OP,
  input wire logic [1:0] I_SRC_SIZE,
  input wire logic [1:0] I_DST_SIZE,
  input wire logic I_SIGNED,
  input wire logic I_MAX,
  input wire logic [7:0] I_IMM,
  input wire logic [VEC_W-1:0] I_SRC_A,
  input wire logic [VEC_W-1:0] I_SRC_B,
  input wire logic [GPR_W-1:0] I_GPR,
  output logic O_VALID,
  output logic O_VEC_WR,
  output logic O_GPR_WR,
  output logic O_FLAGS_WR,
  output logic [VEC_W-1:0] O_VEC,
  output logic [GPR_W-1:0] O_GPR,
  output logic O_ZERO_FLAG,
  output logic O_CARRY_FLAG
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  // all-ones mask of one lane of the given size
  function automatic logic [QWORD_W-1:0] lane_mask(input logic [1:0] sz);
    lane_mask = {QWORD_W{1'b1}} >> (QWORD_W - (BYTE_W << sz));
  endfunction : lane_mask

  // lane a greater than lane b; signed by flipping the top bit
  function automatic logic lane_gt(input logic [QWORD_W-1:0] a,
                                   input logic [QWORD_W-1:0] b,
                                   input logic [1:0] sz,
                                   input logic sgn);
    logic [QWORD_W-1:0] top;
    top = QWORD_W'(sgn) << ((BYTE_W << sz) - 1);
    lane_gt = ((a ^ top) & lane_mask(sz)) > ((b ^ top) & lane_mask(sz));
  endfunction : lane_gt

  // -------------------------------------------------------------
  // widening conversions
  // -------------------------------------------------------------
  logic [VEC_W-1:0] widen_res;
  always_comb begin
    int ew;
    int dw;
    int lane;
    int pos;
    logic sbit;
    lane = 0;
    pos = 0;
    sbit = 1'b0;
    ew = BYTE_W << I_SRC_SIZE;
    dw = BYTE_W << I_DST_SIZE;
    widen_res = '0;
    for (int b = 0; b < VEC_W; b++) begin
      lane = b / dw;
      pos = b % dw;
      sbit = I_SRC_A[(lane * ew + ew - 1) % VEC_W];
      if (pos < ew) begin
        widen_res[b] = I_SRC_A[(lane * ew + pos) % VEC_W];
      end else if (I_OP == OP_SIGN_WIDEN) begin
        widen_res[b] = sbit;
      end else begin
        widen_res[b] = 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // sum of absolute differences
  // -------------------------------------------------------------
  logic [VEC_W-1:0] sad_res;
  psimd_sad u_sad (
    .i_a(I_SRC_A),
    .i_b(I_SRC_B),
    .i_imm(I_IMM),
    .o_sum(sad_res)
  );

  // -------------------------------------------------------------
  // horizontal minimum with position
  // -------------------------------------------------------------
  logic [VEC_W-1:0] hmin_res;
  always_comb begin
    logic [WORD_W-1:0] best;
    logic [HMIN_POS_W-1:0] pos;
    best = I_SRC_A[0 +: WORD_W];
    pos = '0;
    for (int i = 1; i < HMIN_LANES; i++) begin
      // strict less keeps the lowest lane on ties
      if (I_SRC_A[i * WORD_W +: WORD_W] < best) begin
        best = I_SRC_A[i * WORD_W +: WORD_W];
        pos = HMIN_POS_W'(i);
      end
    end
    hmin_res = '0;
    hmin_res[0 +: WORD_W] = best;
    hmin_res[HMIN_POS_LSB +: HMIN_POS_W] = pos;
  end

  // -------------------------------------------------------------
  // quad compares, unsigned pack
  // -------------------------------------------------------------
  logic [VEC_W-1:0] cmp_res;
  logic [VEC_W-1:0] pack_res;
  always_comb begin
    logic [QWORD_W-1:0] qa;
    logic [QWORD_W-1:0] qb;
    logic hit;
    qa = '0;
    qb = '0;
    hit = 1'b0;
    cmp_res = '0;
    for (int q = 0; q < VEC_W / QWORD_W; q++) begin
      qa = I_SRC_A[q * QWORD_W +: QWORD_W];
      qb = I_SRC_B[q * QWORD_W +: QWORD_W];
      if (I_OP == OP_QUAD_EQ) begin
        hit = (qa == qb);
      end else begin
        hit = $signed(qa) > $signed(qb);
      end
      cmp_res[q * QWORD_W +: QWORD_W] = {QWORD_W{hit}};
    end
  end

  always_comb begin
    logic [VEC_W*2-1:0] both;
    logic [DWORD_W-1:0] d;
    d = '0;
    both = {I_SRC_B, I_SRC_A};
    pack_res = '0;
    for (int i = 0; i < VEC_W / WORD_W; i++) begin
      d = both[i * DWORD_W +: DWORD_W];
      if ($signed(d) < $signed(DWORD_ZERO)) begin
        pack_res[i * WORD_W +: WORD_W] = '0;
      end else if (d > DWORD_W'(WORD_MAX)) begin
        pack_res[i * WORD_W +: WORD_W] = WORD_MAX;
      end else begin
        pack_res[i * WORD_W +: WORD_W] = d[WORD_W-1:0];
      end
    end
  end

  // -------------------------------------------------------------
  // per-lane min and max
  // -------------------------------------------------------------
  logic [VEC_W-1:0] mm_res;
  always_comb begin
    int w;
    logic [QWORD_W-1:0] a;
    logic [QWORD_W-1:0] b;
    logic pick_a;
    a = '0;
    b = '0;
    pick_a = 1'b0;
    w = BYTE_W << I_SRC_SIZE;
    mm_res = '0;
    for (int i = 0; i < VEC_W / BYTE_W; i++) begin
      if (i < VEC_W / w) begin
        a = QWORD_W'(I_SRC_A >> (i * w)) & lane_mask(I_SRC_SIZE);
        b = QWORD_W'(I_SRC_B >> (i * w)) & lane_mask(I_SRC_SIZE);
        pick_a = lane_gt(a, b, I_SRC_SIZE, I_SIGNED) == I_MAX;
        mm_res = mm_res
          | (VEC_W'(pick_a ? a : b) << (i * w));
      end
    end
  end

  // -------------------------------------------------------------
  // lane insert and extract, bit count
  // -------------------------------------------------------------
  logic [VEC_W-1:0] ins_res;
  logic [GPR_W-1:0] ext_res;
  logic [GPR_W-1:0] cnt_res;
  always_comb begin
    int sh;
    int nl;
    nl = VEC_W / (BYTE_W << I_SRC_SIZE);
    sh = (int'(I_IMM) % nl) * (BYTE_W << I_SRC_SIZE);
    ins_res = (I_SRC_A & ~(VEC_W'(lane_mask(I_SRC_SIZE)) << sh))
      | (VEC_W'(I_GPR & lane_mask(I_SRC_SIZE)) << sh);
    ext_res = GPR_W'(I_SRC_A >> sh) & lane_mask(I_SRC_SIZE);
  end

  always_comb begin
    logic [CNT_W-1:0] c;
    c = '0;
    for (int i = 0; i < GPR_W; i++) begin
      c = c + CNT_W'(I_GPR[i]);
    end
    cnt_res = GPR_W'(c);
  end

  // -------------------------------------------------------------
  // result select
  // -------------------------------------------------------------
  logic [VEC_W-1:0] vec_nxt;
  logic [GPR_W-1:0] gpr_nxt;
  logic vec_wr_nxt;
  logic gpr_wr_nxt;
  always_comb begin
    vec_nxt = '0;
    gpr_nxt = '0;
    vec_wr_nxt = 1'b1;
    gpr_wr_nxt = 1'b0;
    unique case (I_OP)
      OP_SIGN_WIDEN, OP_ZERO_WIDEN: vec_nxt = widen_res;
      OP_MULTI_SAD: vec_nxt = sad_res;
      OP_HMIN_POS: vec_nxt = hmin_res;
      OP_MASKED_TEST: vec_wr_nxt = 1'b0;
      OP_QUAD_EQ, OP_QUAD_GT: vec_nxt = cmp_res;
      OP_PACK_US: vec_nxt = pack_res;
      OP_SET_BIT_COUNT: begin
        vec_wr_nxt = 1'b0;
        gpr_wr_nxt = 1'b1;
        gpr_nxt = cnt_res;
      end
      OP_LANE_INSERT: vec_nxt = ins_res;
      OP_LANE_EXTRACT: begin
        vec_wr_nxt = 1'b0;
        gpr_wr_nxt = 1'b1;
        gpr_nxt = ext_res;
      end
      OP_LANE_MINMAX: vec_nxt = mm_res;
      default: vec_wr_nxt = 1'b0;
    endcase
  end

  // -------------------------------------------------------------
  // output registers
  // -------------------------------------------------------------
  // strobes for one cycle after each request
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_VALID <= 1'b0;
      O_VEC_WR <= 1'b0;
      O_GPR_WR <= 1'b0;
      O_FLAGS_WR <= 1'b0;
    end else begin
      O_VALID <= I_VALID;
      O_VEC_WR <= I_VALID & vec_wr_nxt;
      O_GPR_WR <= I_VALID & gpr_wr_nxt;
      O_FLAGS_WR <= I_VALID & (I_OP == OP_MASKED_TEST);
    end
  end

  // data results, captured on each request
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_VEC <= '0;
      O_GPR <= '0;
    end else if (I_VALID) begin
      O_VEC <= vec_nxt;
      O_GPR <= gpr_nxt;
    end
  end

  // flags change only on the masked test
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ZERO_FLAG <= 1'b0;
      O_CARRY_FLAG <= 1'b0;
    end else if (I_VALID && I_OP == OP_MASKED_TEST) begin
      O_ZERO_FLAG <= ~|(I_SRC_A & I_SRC_B);
      O_CARRY_FLAG <= ~|(I_SRC_A & ~I_SRC_B);
    end
  end

endmodule : psimd_top

// File: sim/psimd_top_checker.sv
// psimd_top_checker: timing and flag relations at the datapath ports
// assumes: bound to psimd_top; one clock, async active-high reset
`timescale 1ns/1ps
module psimd_top_checker
  import psimd_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_VALID,
  input wire psimd_op_e I_OP,
  input wire logic [VEC_W-1:0] I_SRC_A,
  input wire logic [VEC_W-1:0] I_SRC_B,
  input wire logic [GPR_W-1:0] I_GPR,
  input wire logic O_VALID,
  input wire logic O_VEC_WR,
  input wire logic O_GPR_WR,
  input wire logic O_FLAGS_WR,
  input wire logic [VEC_W-1:0] O_VEC,
  input wire logic [GPR_W-1:0] O_GPR,
  input wire logic O_ZERO_FLAG,
  input wire logic O_CARRY_FLAG
);
  // ----------------------------------------------
  // request and answer relations
  // ----------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // masked test and bit count requests
  wire tst = I_VALID && I_OP == OP_MASKED_TEST;
  wire cnt = I_VALID && I_OP == OP_SET_BIT_COUNT;
  answer_one_cycle_a: assert property (I_VALID |=> O_VALID)
    else $error("answer missing");
  no_spurious_a: assert property (!I_VALID |=> !(O_VALID || O_VEC_WR ||
    O_GPR_WR || O_FLAGS_WR)) else $error("strobe without request");
  one_strobe_a: assert property (O_VALID |->
    $onehot({O_VEC_WR, O_GPR_WR, O_FLAGS_WR})) else $error("strobe count");
  test_no_write_a: assert property (
    tst |=> O_FLAGS_WR && !O_VEC_WR && !O_GPR_WR)
    else $error("test wrote a register");
  zero_flag_a: assert property (
    tst |=> O_ZERO_FLAG == ~|($past(I_SRC_A) & $past(I_SRC_B)))
    else $error("zero flag");
  carry_flag_a: assert property (
    tst |=> O_CARRY_FLAG == ~|($past(I_SRC_A) & ~$past(I_SRC_B)))
    else $error("carry");
  flags_hold_a: assert property (
    !tst |=> $stable({O_ZERO_FLAG, O_CARRY_FLAG}))
    else $error("flags moved");
  bit_count_a: assert property (
    cnt |=> O_GPR == 64'($countones($past(I_GPR))))
    else $error("bit count");
  hmin_upper_a: assert property (
    I_VALID && I_OP == OP_HMIN_POS |=> O_VEC[127:19] == '0)
    else $error("min search upper bits");
  quad_eq_hi_a: assert property (
    I_VALID && I_OP == OP_QUAD_EQ |=>
    O_VEC[127:64] == {64{~|(($past(I_SRC_A) ^ $past(I_SRC_B)) >> 64)}})
    else $error("quad equal upper lane");
  cover property (tst ##1 O_ZERO_FLAG && O_CARRY_FLAG);
  cover property (tst ##1 !O_ZERO_FLAG && !O_CARRY_FLAG);
  cover property (cnt ##1 O_GPR_WR);
endmodule : psimd_top_checker

bind psimd_top psimd_top_checker u_chk (.I_CLK, .I_RST, .I_VALID, .I_OP,
  .I_SRC_A, .I_SRC_B, .I_GPR, .O_VALID, .O_VEC_WR, .O_GPR_WR, .O_FLAGS_WR,
  .O_VEC, .O_GPR, .O_ZERO_FLAG, .O_CARRY_FLAG);

// File: sim/psimd_regfile.sv
// psimd_regfile: vector register slot fed by the datapath writeback
// assumes: same clock and reset as psimd_top
`timescale 1ns/1ps
module psimd_regfile
  import psimd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_vec_wr,
  input wire logic [VEC_W-1:0] i_vec,
  output logic [VEC_W-1:0] o_vec_r
);
  // written only on a vector writeback strobe
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_vec_r <= '0;
    end else if (i_vec_wr) begin
      o_vec_r <= i_vec;
    end
  end
endmodule : psimd_regfile

// File: sim/psimd_top_tb_top.sv
// psimd_top_tb_top: directed scenarios for the packed datapath
// assumes: psimd_pkg, psimd_top, regfile model and checker compiled first
`timescale 1ns/1ps
module psimd_top_tb_top;
  import psimd_pkg::*;
  logic clk, rst, vld, sgn, mx, ov, ovw, ogw, ozf, ocf;
  psimd_op_e op;
  logic [1:0] ssz, dsz;
  logic [7:0] imm;
  logic [127:0] sa, sb, ovec, rfv, e;
  logic [63:0] gpr, ogpr;
  int err_count, num_checks, cyc;

  psimd_top uut (.I_CLK(clk), .I_RST(rst), .I_VALID(vld), .I_OP(op),
    .I_SRC_SIZE(ssz), .I_DST_SIZE(dsz), .I_SIGNED(sgn), .I_MAX(mx),
    .I_IMM(imm), .I_SRC_A(sa), .I_SRC_B(sb), .I_GPR(gpr), .O_VALID(ov),
    .O_VEC_WR(ovw), .O_GPR_WR(ogw), .O_FLAGS_WR(), .O_VEC(ovec),
    .O_GPR(ogpr), .O_ZERO_FLAG(ozf), .O_CARRY_FLAG(ocf));
  psimd_regfile rf (.i_clk(clk), .i_rst(rst), .i_vec_wr(ovw),
    .i_vec(ovec), .o_vec_r(rfv));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end

  task cmp(input logic [127:0] g, input logic [127:0] x);
    num_checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp

  // one request pulse; returns with the answer settled
  task go(input psimd_op_e o);
    @(negedge clk);
    op = o;
    vld = 1'b1;
    @(negedge clk);
    vld = 1'b0;
    cmp({127'h0, ov}, 128'h1);
  endtask : go

  task t_widen;
    sa = 128'h0123_4567_89ab_cdef_7f80_ff01_8000_7fff;
    for (int c = 0; c < 16; c++) begin
      ssz = 2'(c / 4 % 3);
      dsz = (c / 4 % 3 + 1 + c / 2 % 2 > 3) ? 2'h3 :
        2'(c / 4 % 3 + 1 + c / 2 % 2);
      go(c[0] ? OP_SIGN_WIDEN : OP_ZERO_WIDEN);
      for (int k = 0; k < 128; k++)
        e[k] = (k % (8 << dsz) < (8 << ssz)) ?
          sa[k / (8 << dsz) * (8 << ssz) + k % (8 << dsz)] :
          (c[0] & sa[k / (8 << dsz) * (8 << ssz) + (8 << ssz) - 1]);
      cmp(ovec, e);
    end
  endtask : t_widen

  task t_sad;
    int t, d;
    sa = 128'h00ff_10f0_8001_7f20_ff00_0102_fe03_0480;
    sb = 128'h0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2_e1f0;
    for (int m = 0; m < 8; m++) begin
      imm = 8'(m);
      go(OP_MULTI_SAD);
      for (int i = 0; i < 8; i++) begin
        t = 0;
        for (int k = 0; k < 4; k++) begin
          d = int'(sa[(m / 4 * 4 + i + k) * 8+:8])
            - int'(sb[(m % 4 * 4 + k) * 8+:8]);
          t += d < 0 ? -d : d;
        end
        e[i * 16+:16] = 16'(t);
      end
      cmp(ovec, e);
    end
    sa = 128'h9000_0003_7fff_0003_ffff_1234_0010_8000;
    go(OP_HMIN_POS);
    cmp(ovec, {109'h0, 3'h4, 16'h0003});
  endtask : t_sad

  // four mask cases, last one leaves both flags set
  task t_test;
    logic [127:0] ta[4], tb[4], keep;
    ta = '{128'h0f, 128'h0f, 128'hff, 128'h0};
    tb = '{128'hf0, 128'h0f, 128'h0f, 128'hff};
    @(negedge clk);
    keep = rfv;
    for (int c = 0; c < 4; c++) begin
      sa = ta[c] << 64 | ta[c];
      sb = tb[c] << 64 | tb[c];
      go(OP_MASKED_TEST);
      cmp({ozf, ocf, ovw, ogw},
        {~|(sa & sb), ~|(sa & ~sb), 2'h0});
    end
    @(negedge clk);
    cmp(rfv, keep);
    gpr = 64'hf0f0_0000_0000_0001;
    go(OP_SET_BIT_COUNT);
    cmp({ozf, ocf, ogpr}, {2'h3, 64'h9});
  endtask : t_test

  task t_misc;
    logic signed [31:0] v;
    sa = 128'h8000_0000_0000_0000_0000_0000_0000_0005;
    sb = 128'h0000_0000_0000_0001_0000_0000_0000_0005;
    for (int r = 0; r < 2; r++) begin
      go(OP_QUAD_EQ);
      for (int i = 0; i < 2; i++)
        e[i * 64+:64] = {64{sa[i * 64+:64] == sb[i * 64+:64]}};
      cmp(ovec, e);
      go(OP_QUAD_GT);
      for (int i = 0; i < 2; i++)
        e[i * 64+:64] =
          {64{$signed(sa[i * 64+:64]) > $signed(sb[i * 64+:64])}};
      cmp(ovec, e);
      {sa, sb} = {sb, sa};
    end
    sa = 128'h0001_0000_ffff_ffff_0000_ffff_0000_1234;
    sb = 128'h8000_0000_7fff_ffff_0000_0000_0000_8000;
    go(OP_PACK_US);
    for (int i = 0; i < 8; i++) begin
      v = i < 4 ? sa[i * 32+:32] : sb[(i - 4) * 32+:32];
      e[i * 16+:16] = v < 0 ? 16'h0 : (v > 32'sh0000ffff ? 16'hffff : v[15:0]);
    end
    cmp(ovec, e);
  endtask : t_misc

  // lane 13 taken modulo the lane count of each size
  task t_lane;
    logic [63:0] g;
    int w, l;
    sa = 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100;
    gpr = 64'hfedc_ba98_7654_3210;
    imm = 8'h0d;
    for (int s = 0; s < 4; s++) begin
      ssz = 2'(s);
      w = 8 << s;
      l = 13 % (16 >> s);
      e = sa;
      g = '0;
      for (int j = 0; j < w; j++) begin
        e[l * w + j] = gpr[j];
        g[j] = sa[l * w + j];
      end
      go(OP_LANE_INSERT);
      cmp(ovec, e);
      cmp({ovw, ogw}, 2'h2);
      go(OP_LANE_EXTRACT);
      cmp({64'h0, ogpr}, {64'h0, g});
      cmp({ovw, ogw}, 2'h1);
    end
  endtask : t_lane

  task t_mm;
    logic signed [64:0] x, y;
    int w;
    sa = 128'h8000_0001_7fff_ff80_0102_fe7f_80ff_0000;
    sb = 128'h7fff_0002_8000_0001_ff01_02fe_7f00_ffff;
    for (int c = 0; c < 16; c++) begin
      ssz = 2'(c / 4);
      sgn = c[1];
      mx = c[0];
      w = 8 << (c / 4);
      go(OP_LANE_MINMAX);
      for (int i = 0; i < 128 / w; i++) begin
        for (int j = 0; j < 65; j++) begin
          x[j] = j < w ? sa[i * w + j] : sgn & sa[i * w + w - 1];
          y[j] = j < w ? sb[i * w + j] : sgn & sb[i * w + w - 1];
        end
        for (int j = 0; j < w; j++)
          e[i * w + j] = ((x > y) == mx) ? sa[i * w + j] : sb[i * w + j];
      end
      cmp(ovec, e);
    end
  endtask : t_mm

  task final_report;
    if (err_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  // reset, then every scenario in turn
  initial begin
    {rst, vld, sgn, mx, ssz, dsz, imm, sa, sb, gpr} = '0;
    rst = 1'b1;
    op = OP_SIGN_WIDEN;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_widen();
    t_sad();
    t_test();
    t_misc();
    t_lane();
    t_mm();
    final_report();
  end
endmodule : psimd_top_tb_top
